// [hw/shp_defines.svh]
`ifndef SHP_DEFINES_SVH
`define SHP_DEFINES_SVH
// receive clock factor codes
`define SHP_CLK_X1 2'h0
`define SHP_CLK_X16 2'h1
`define SHP_CLK_X32 2'h2
`define SHP_CLK_X64 2'h3
// receive mode codes
`define SHP_MODE_ASYNC 2'h0
`define SHP_MODE_EXTSYNC 2'h1
`define SHP_MODE_INTSYNC 2'h2
`define SHP_MODE_FRAME 2'h3
// terminal-ready pin use
`define SHP_TR_LEVEL 2'h0
`define SHP_TR_GPO 2'h1
`define SHP_TR_DMA 2'h2
// multiplexed address field width
`define SHP_ADDR_W 8
// reset value of the wait/request function select (0 = wait)
`define SHP_WREQ_RST 1'b0
`endif

// [hw/shp_host_port.sv]
`timescale 1ns/1ns
`include "shp_defines.svh"
module shp_host_port (
  // clocking
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // bus form select: 1 = multiplexed
  input wire logic muxed_mode_in,
  // non-multiplexed bus
  input wire logic chan_sel_in,
  input wire logic chip_en_n_in,
  input wire logic data_cmd_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  // multiplexed bus
  input wire logic addr_strobe_n_in,
  input wire logic data_strobe_n_in,
  input wire logic chip_sel_lo_n_in,
  input wire logic chip_sel_hi_in,
  input wire logic rd_wr_in,
  input wire logic [7:0] muxed_addr_data_in,
  // interrupt chain
  input wire logic chain_in,
  output logic chain_out,
  input wire logic irq_ack_n_in,
  input wire logic irq_pending_in,
  input wire logic irq_under_service_in,
  input wire logic [7:0] vector_in,
  output logic irq_n_out,
  output logic irq_n_oe_out,
  output logic ack_taken_out,
  // core access and read data
  output shp_pkg::shp_access_s access_out,
  input wire logic [7:0] rdata_in,
  output logic hw_reset_out,
  // wait/request per channel
  input wire logic [1:0] wreq_is_dma_in,
  input wire logic [1:0] wreq_level_in,
  output logic [1:0] wreq_out,
  output logic [1:0] wreq_oe_out,
  output logic [1:0] wreq_is_dma_out,
  // modem per channel
  input wire shp_pkg::shp_chan_cfg_s [1:0] cfg_in,
  input wire shp_pkg::shp_modem_in_s [1:0] modem_in,
  input wire logic [1:0] rx_clk_in,
  input wire logic [1:0] tx_empty_in,
  input wire logic [1:0] sync_hit_in,
  input wire logic [1:0] flag_hit_in,
  output shp_pkg::shp_chan_stat_s [1:0] stat_out,
  output logic [1:0] rts_n_out,
  output logic [1:0] tr_n_out,
  output logic [1:0] sync_out,
  output logic [1:0] sync_oe_out
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: strobes, selects, ack, modem pins, rx clocks
  localparam int NS = 10;
  localparam int NM = 8;
  logic [NS-1:0] strb_raw, strb_s;
  logic [NM-1:0] mdm_raw, mdm_s;
  assign strb_raw = {chain_in, irq_ack_n_in, rd_wr_in, chip_sel_hi_in,
      chip_sel_lo_n_in, data_strobe_n_in, addr_strobe_n_in, wr_n_in,
      rd_n_in, chip_en_n_in};
  assign mdm_raw = {rx_clk_in, modem_in[1], modem_in[0]};
  shp_sync2 #(.W(NS)) u_sync_bus (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .d_in(strb_raw),
    .rst_val_in({NS{1'b1}}),
    .q_out(strb_s)
  );
  shp_sync2 #(.W(NM)) u_sync_mdm (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .d_in(mdm_raw),
    .rst_val_in({NM{1'b1}}),
    .q_out(mdm_s)
  );
  logic ce_n, rd_n, wr_n, as_n, ds_n, cs0_n, cs1, rw, ack_n, chain;
  assign {chain, ack_n, rw, cs1, cs0_n, ds_n, as_n, wr_n, rd_n, ce_n} =
      strb_s;
  // data lines are sampled only when strobes are already stable
  ////////////////////////////////////////////////////////////////////////////
  // strobe edge tracking
  logic rd_n_d, wr_n_d, as_n_d, ds_n_d;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_n_d <= 1'b1;
      wr_n_d <= 1'b1;
      as_n_d <= 1'b1;
      ds_n_d <= 1'b1;
    end else if (clk_en_in) begin
      rd_n_d <= rd_n;
      wr_n_d <= wr_n;
      as_n_d <= as_n;
      ds_n_d <= ds_n;
    end
  end
  // both forms' reset coincidences
  always_comb begin
    if (muxed_mode_in) begin
      hw_reset_out = !as_n && !ds_n;
    end else begin
      hw_reset_out = !rd_n && !wr_n;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // multiplexed address phase
  logic [`SHP_ADDR_W-1:0] addr_lat;
  logic cs0_lat;
  shp_pkg::shp_bus_e bus_st;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      addr_lat <= 8'h00;
      cs0_lat <= 1'b0;
    end else if (clk_en_in && as_n && !as_n_d) begin
      addr_lat <= muxed_addr_data_in;
      cs0_lat <= !cs0_n;
    end
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_st <= shp_pkg::SHP_IDLE;
    end else if (clk_en_in) begin
      unique case (bus_st)
        shp_pkg::SHP_IDLE: if (!as_n) bus_st <= shp_pkg::SHP_ADDR;
        shp_pkg::SHP_ADDR: if (as_n) bus_st <= shp_pkg::SHP_DATA;
        shp_pkg::SHP_DATA: if (!ds_n_d && ds_n) bus_st <= shp_pkg::SHP_IDLE;
        default: bus_st <= shp_pkg::SHP_IDLE;
      endcase
    end
  end
  logic mux_sel, plain_sel, sel;
  // the second select is the host's to hold; dropping it aborts the access
  assign mux_sel = (bus_st == shp_pkg::SHP_DATA) && cs0_lat && cs1;
  assign plain_sel = !ce_n;
  assign sel = muxed_mode_in ? mux_sel : plain_sel;
  ////////////////////////////////////////////////////////////////////////////
  // access pulses to the core, on the strobe's leading edge
  logic rd_go, wr_go, rd_act;
  always_comb begin
    if (muxed_mode_in) begin
      rd_act = !ds_n && rw;
      rd_go = !ds_n && ds_n_d && rw;
      wr_go = !ds_n && ds_n_d && !rw;
    end else begin
      rd_act = !rd_n;
      rd_go = !rd_n && rd_n_d;
      wr_go = !wr_n && wr_n_d;
    end
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      access_out <= '0;
    end else if (clk_en_in) begin
      access_out.rd <= rd_go && sel && ack_n && !hw_reset_out;
      access_out.wr <= wr_go && sel && ack_n && !hw_reset_out;
      access_out.is_data <= muxed_mode_in ? 1'b0 : data_cmd_in;
      access_out.chan_b <= muxed_mode_in ? addr_lat[0] : !chan_sel_in;
      access_out.addr <= muxed_mode_in ? addr_lat : 8'h00;
      access_out.wdata <= muxed_mode_in ? muxed_addr_data_in : data_in;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // interrupt chain
  logic in_ack;
  assign in_ack = !ack_n;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      chain_out <= 1'b0;
    end else if (clk_en_in) begin
      // requesting only blocks the chain during acknowledge
      chain_out <= chain && !irq_under_service_in &&
          !(in_ack && irq_pending_in);
    end
  end
  assign irq_n_out = 1'b0;
  assign irq_n_oe_out = irq_pending_in && chain;
  assign ack_taken_out = in_ack && rd_act && rd_go && chain;
  ////////////////////////////////////////////////////////////////////////////
  // data bus drive
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
    end else if (clk_en_in) begin
      if (in_ack && rd_act && chain) begin
        data_out <= vector_in;
        data_oe_out <= 1'b1;
      end else if (!in_ack && rd_act && sel && !hw_reset_out) begin
        data_out <= rdata_in;
        data_oe_out <= 1'b1;
      end else begin
        data_oe_out <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // wait/request pins and modem channels
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      logic dma_sel;
      always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          dma_sel <= `SHP_WREQ_RST;
        end else if (clk_en_in) begin
          dma_sel <= wreq_is_dma_in[c];
        end
      end
      assign wreq_is_dma_out[c] = dma_sel;
      // wait only pulls low; request drives both levels
      assign wreq_out[c] = dma_sel ? ~wreq_level_in[c] : 1'b0;
      assign wreq_oe_out[c] = dma_sel | wreq_level_in[c];
      shp_modem_chan u_chan (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .cfg_in(cfg_in[c]),
        .pins_in(mdm_s[3*c +: 3]),
        .rx_clk_in(mdm_s[6+c]),
        .tx_empty_in(tx_empty_in[c]),
        .sync_hit_in(sync_hit_in[c]),
        .flag_hit_in(flag_hit_in[c]),
        .stat_out(stat_out[c]),
        .rts_n_out(rts_n_out[c]),
        .tr_n_out(tr_n_out[c]),
        .sync_out(sync_out[c]),
        .sync_oe_out(sync_oe_out[c])
      );
    end
  endgenerate
  // is the far side's duty; assembly start relies on it
endmodule

// [hw/shp_modem_chan.sv]
`timescale 1ns/1ns
`include "shp_defines.svh"
module shp_modem_chan (
  // clocking
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // config and pins (pins already synchronised)
  input wire shp_pkg::shp_chan_cfg_s cfg_in,
  input wire shp_pkg::shp_modem_in_s pins_in,
  input wire logic rx_clk_in,
  input wire logic tx_empty_in,
  input wire logic sync_hit_in,
  input wire logic flag_hit_in,
  // outputs
  output shp_pkg::shp_chan_stat_s stat_out,
  output logic rts_n_out,
  output logic tr_n_out,
  output logic sync_out,
  output logic sync_oe_out
);
  logic cts_d, dcd_d, sync_d, rxc_d, rts_n;
  logic [5:0] div;
  logic rx_rise;
  assign rx_rise = rx_clk_in & ~rxc_d;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cts_d <= 1'b1;
      dcd_d <= 1'b1;
      sync_d <= 1'b1;
      // matches the synchroniser's reset level, so no false rise
      rxc_d <= 1'b1;
    end else if (clk_en_in) begin
      cts_d <= pins_in.cts_n;
      dcd_d <= pins_in.dcd_n;
      sync_d <= pins_in.sync_n;
      rxc_d <= rx_clk_in;
    end
  end
  // rx clock prescale by the chosen factor
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div <= 6'h00;
    end else if (clk_en_in && rx_rise) begin
      div <= div + 6'h01;
    end
  end
  always_comb begin
    unique case (cfg_in.clk_factor)
      `SHP_CLK_X1: stat_out.rx_sample = rx_rise;
      `SHP_CLK_X16: stat_out.rx_sample = rx_rise && div[3:0] == 4'hf;
      `SHP_CLK_X32: stat_out.rx_sample = rx_rise && div[4:0] == 5'h1f;
      `SHP_CLK_X64: stat_out.rx_sample = rx_rise && div == 6'h3f;
    endcase
  end
  // pulses in either direction are reported
  assign stat_out.cts_edge = cts_d ^ pins_in.cts_n;
  assign stat_out.dcd_edge = dcd_d ^ pins_in.dcd_n;
  assign stat_out.cts_lvl = ~pins_in.cts_n;
  assign stat_out.dcd_lvl = ~pins_in.dcd_n;
  assign stat_out.tx_enable = ~cfg_in.auto_en | ~pins_in.cts_n;
  assign stat_out.rx_enable = ~cfg_in.auto_en | ~pins_in.dcd_n;
  // async mode: sync pin only steers the hunt bit
  assign stat_out.sync_hunt = (cfg_in.rx_mode == `SHP_MODE_ASYNC) &&
      !cfg_in.xtal_sel && !pins_in.sync_n;
  // ext sync: assembly starts in the cycle the synchronised sync pin first reads low
  assign stat_out.start_assembly = (cfg_in.rx_mode == `SHP_MODE_EXTSYNC) &&
      sync_d && !pins_in.sync_n;
  always_comb begin
    sync_oe_out = 1'b0;
    sync_out = 1'b1;
    if (!cfg_in.xtal_sel) begin
      if (cfg_in.rx_mode == `SHP_MODE_INTSYNC) begin
        sync_oe_out = 1'b1;
        sync_out = ~sync_hit_in;
      end else if (cfg_in.rx_mode == `SHP_MODE_FRAME) begin
        sync_oe_out = 1'b1;
        sync_out = ~flag_hit_in;
      end
    end
  end
  // rts: async auto mode waits for the transmitter to drain
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rts_n <= 1'b1;
    end else if (clk_en_in) begin
      if (cfg_in.rts_bit || cfg_in.sync_mode || !cfg_in.auto_en) begin
        rts_n <= ~cfg_in.rts_bit;
      end else if (tx_empty_in) begin
        rts_n <= 1'b1;
      end
    end
  end
  assign rts_n_out = rts_n;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tr_n_out <= 1'b1;
    end else if (clk_en_in) begin
      unique case (cfg_in.tr_use)
        `SHP_TR_GPO: tr_n_out <= ~cfg_in.gpo;
        `SHP_TR_DMA: tr_n_out <= ~cfg_in.dma_req;
        default: tr_n_out <= ~cfg_in.tr_bit;
      endcase
    end
  end
endmodule

// [hw/shp_pkg.sv]
package shp_pkg;
  // per-channel configuration
  typedef struct packed {
    logic auto_en;
    logic sync_mode;
    logic [1:0] rx_mode;
    logic [1:0] clk_factor;
    logic xtal_sel;
    logic rts_bit;
    logic tr_bit;
    logic [1:0] tr_use;
    logic gpo;
    logic dma_req;
    logic wreq_is_dma;
    logic wreq_level;
  } shp_chan_cfg_s;
  // per-channel modem pin inputs, active low
  typedef struct packed {
    logic cts_n;
    logic dcd_n;
    logic sync_n;
  } shp_modem_in_s;
  // per-channel status toward the core
  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic cts_edge;
    logic dcd_edge;
    logic sync_hunt;
    logic cts_lvl;
    logic dcd_lvl;
    logic start_assembly;
    logic rx_sample;
  } shp_chan_stat_s;
  // host access decoded to the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic is_data;
    logic chan_b;
    logic [7:0] addr;
    logic [7:0] wdata;
  } shp_access_s;
  typedef enum logic [2:0] {
    SHP_IDLE = 3'b001,
    SHP_ADDR = 3'b010,
    SHP_DATA = 3'b100
  } shp_bus_e;
endpackage

// [hw/shp_sync2.sv]
`timescale 1ns/1ns
module shp_sync2 #(
  parameter int W = 1
) (
  // clocking
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // data
  input wire logic [W-1:0] d_in,
  input wire logic [W-1:0] rst_val_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;
  // reset value is always 1 for every bit; the rst_val_in port is unused
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          meta[i] <= 1'b1;
          q_out[i] <= 1'b1;
        end else if (clk_en_in) begin
          meta[i] <= d_in[i];
          q_out[i] <= meta[i];
        end
      end
    end
  endgenerate
  logic unused_rst;
  assign unused_rst = |rst_val_in;
endmodule

// [verif/shp_host_model.sv]
`timescale 1ns/1ns
module shp_host_model (
  // clocking
  input wire logic sys_clk_in,
  // plain bus
  output logic chan_sel_out,
  output logic chip_en_n_out,
  output logic data_cmd_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [7:0] data_out,
  // multiplexed bus
  output logic addr_strobe_n_out,
  output logic data_strobe_n_out,
  output logic chip_sel_lo_n_out,
  output logic chip_sel_hi_out,
  output logic rd_wr_out,
  output logic [7:0] muxed_addr_data_out
);
  initial begin
    {chan_sel_out, data_cmd_out, chip_sel_hi_out, rd_wr_out} = 4'h0;
    {chip_en_n_out, rd_n_out, wr_n_out} = 3'h7;
    {addr_strobe_n_out, data_strobe_n_out, chip_sel_lo_n_out} = 3'h7;
    data_out = 8'h00;
    muxed_addr_data_out = 8'h00;
  end
  task plain(input logic rd, input logic ch, input logic dc,
             input logic [7:0] wd);
    @(negedge sys_clk_in);
    {chan_sel_out, data_cmd_out, data_out} = {ch, dc, wd};
    {chip_en_n_out, rd_n_out, wr_n_out} = {1'b0, !rd, rd};
    repeat (6) @(negedge sys_clk_in);
    {chip_en_n_out, rd_n_out, wr_n_out} = 3'h7;
    // a released bus must not keep showing the last byte
    data_out = ~wd;
    repeat (4) @(negedge sys_clk_in);
  endtask
  task strobes(input logic rn, input logic wn);
    @(negedge sys_clk_in);
    {rd_n_out, wr_n_out} = {rn, wn};
  endtask
  task muxed(input logic rd, input logic [7:0] a, input logic [7:0] wd);
    @(negedge sys_clk_in);
    chip_sel_hi_out = 1'b1;
    {chip_sel_lo_n_out, muxed_addr_data_out, rd_wr_out} = {1'b0, a, rd};
    addr_strobe_n_out = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    addr_strobe_n_out = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    {chip_sel_lo_n_out, muxed_addr_data_out} = {1'b1, wd};
    data_strobe_n_out = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    data_strobe_n_out = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    chip_sel_hi_out = 1'b0;
    muxed_addr_data_out = ~wd;
  endtask
endmodule

// [verif/shp_port_monitor.sv]
`timescale 1ns/1ns
module shp_port_monitor (
  // clocking
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // host side
  input wire logic muxed_mode_in,
  input wire logic chan_sel_in,
  input wire logic chip_en_n_in,
  input wire logic data_cmd_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic data_oe_out,
  input wire logic hw_reset_out,
  input wire shp_pkg::shp_access_s access_out,
  // interrupt chain
  input wire logic chain_in,
  input wire logic chain_out,
  input wire logic irq_pending_in,
  input wire logic irq_under_service_in,
  input wire logic irq_n_oe_out,
  // modem
  input wire shp_pkg::shp_chan_cfg_s [1:0] cfg_in,
  input wire shp_pkg::shp_modem_in_s [1:0] modem_in,
  input wire shp_pkg::shp_chan_stat_s [1:0] stat_out,
  input wire logic [1:0] rts_n_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////////////////
  // strobes held past the two-flop synchroniser
  sequence s_both_low;
    (!rd_n_in && !wr_n_in && !muxed_mode_in) [*4];
  endsequence
  sequence s_deselected;
    (chip_en_n_in && !muxed_mode_in) [*6];
  endsequence
  property p_coincide;
    s_both_low |-> hw_reset_out;
  endproperty
  a_coincide: assert property (p_coincide) else $error("no reset");
  property p_bus_idle;
    s_deselected |-> !data_oe_out;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("bus driven");
  property p_chain_block;
    (!chain_in || irq_under_service_in) [*6] |-> !chain_out;
  endproperty
  a_chain_block: assert property (p_chain_block) else $error("chain");
  property p_irq_quiet;
    !irq_pending_in [*4] |-> !irq_n_oe_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq low");
  property p_wr_pulse;
    access_out.wr |=> !access_out.wr;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("long write");
  property p_decode;
    access_out.wr && !muxed_mode_in |-> access_out.is_data ==
      $past(data_cmd_in, 2) && access_out.chan_b == !$past(chan_sel_in, 2);
  endproperty
  a_decode: assert property (p_decode) else $error("decode");
  property p_rts_sync;
    (cfg_in[1].sync_mode && !hw_reset_out) [*2] |->
      rts_n_out[1] == !$past(cfg_in[1].rts_bit);
  endproperty
  a_rts_sync: assert property (p_rts_sync) else $error("rts");
  property p_tx_gate;
    (cfg_in[0].auto_en && modem_in[0].cts_n) [*4] |-> !stat_out[0].tx_enable;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx gate");
endmodule
bind shp_host_port shp_port_monitor u_mon (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .muxed_mode_in(muxed_mode_in), .chan_sel_in(chan_sel_in),
  .chip_en_n_in(chip_en_n_in), .data_cmd_in(data_cmd_in),
  .rd_n_in(rd_n_in), .wr_n_in(wr_n_in), .data_oe_out(data_oe_out),
  .hw_reset_out(hw_reset_out), .access_out(access_out),
  .chain_in(chain_in), .chain_out(chain_out),
  .irq_pending_in(irq_pending_in), .irq_n_oe_out(irq_n_oe_out),
  .irq_under_service_in(irq_under_service_in), .cfg_in(cfg_in),
  .modem_in(modem_in), .stat_out(stat_out), .rts_n_out(rts_n_out));

// [verif/testbench.sv]
`timescale 1ns/1ns
module testbench;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic muxed_mode_in = 1'b0;
  logic chain_in = 1'b1;
  logic irq_ack_n_in = 1'b1;
  logic irq_pending_in = 1'b0;
  logic irq_under_service_in = 1'b0;
  logic [7:0] vector_in = 8'hc3;
  logic [7:0] rdata_in = 8'h5a;
  logic [1:0] wreq_is_dma_in = 2'h0;
  logic [1:0] wreq_level_in = 2'h0;
  logic [1:0] tx_empty_in = 2'h0;
  shp_pkg::shp_chan_cfg_s [1:0] cfg_in = '0;
  shp_pkg::shp_modem_in_s [1:0] modem_in = '1;
  logic cs, ce_n, dc, rd_n, wr_n, as_n, ds_n, cs0_n, cs1, rw;
  logic [7:0] dbus, adbus, data_out;
  logic data_oe_out, chain_out, hw_reset_out, irq_n_oe_out;
  logic [1:0] rts_n_out, tr_n_out, wreq_oe_out, wreq_is_dma_out;
  shp_pkg::shp_access_s access_out;
  shp_pkg::shp_access_s last_acc = '0;
  logic [7:0] read_byte = 8'h00;
  shp_pkg::shp_chan_stat_s [1:0] stat;
  logic [1:0] sync_out, sync_oe_out;
  logic [1:0] sync_hit_in = 2'h0;
  logic ack_taken_out;
  logic ack_seen = 1'b0;
  logic rx_seen = 1'b0;
  logic edge_seen = 1'b0;
  int errors = 0;
  int compares = 0;
  always #10 sys_clk_in = ~sys_clk_in;
  shp_host_model u_host (.sys_clk_in(sys_clk_in), .chan_sel_out(cs),
    .chip_en_n_out(ce_n), .data_cmd_out(dc), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .data_out(dbus), .addr_strobe_n_out(as_n),
    .data_strobe_n_out(ds_n), .chip_sel_lo_n_out(cs0_n),
    .chip_sel_hi_out(cs1), .rd_wr_out(rw), .muxed_addr_data_out(adbus));
  shp_host_port u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(1'b1), .muxed_mode_in(muxed_mode_in), .chan_sel_in(cs),
    .chip_en_n_in(ce_n), .data_cmd_in(dc), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .data_in(dbus), .data_out(data_out), .data_oe_out(data_oe_out),
    .addr_strobe_n_in(as_n), .data_strobe_n_in(ds_n),
    .chip_sel_lo_n_in(cs0_n), .chip_sel_hi_in(cs1), .rd_wr_in(rw),
    .muxed_addr_data_in(adbus), .chain_in(chain_in),
    .chain_out(chain_out), .irq_ack_n_in(irq_ack_n_in),
    .irq_pending_in(irq_pending_in), .vector_in(vector_in),
    .irq_under_service_in(irq_under_service_in), .irq_n_out(),
    .irq_n_oe_out(irq_n_oe_out), .ack_taken_out(ack_taken_out),
    .access_out(access_out), .rdata_in(rdata_in),
    .hw_reset_out(hw_reset_out), .wreq_is_dma_in(wreq_is_dma_in),
    .wreq_level_in(wreq_level_in), .wreq_out(), .wreq_oe_out(wreq_oe_out),
    .wreq_is_dma_out(wreq_is_dma_out), .cfg_in(cfg_in),
    .modem_in(modem_in), .rx_clk_in(2'h0), .tx_empty_in(tx_empty_in),
    .sync_hit_in(sync_hit_in), .flag_hit_in(2'h0), .stat_out(stat),
    .rts_n_out(rts_n_out), .tr_n_out(tr_n_out), .sync_out(sync_out),
    .sync_oe_out(sync_oe_out));
  ////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_in) begin
    if (access_out.wr || access_out.rd) last_acc <= access_out;
    if (data_oe_out) read_byte <= data_out;
    if (ack_taken_out) ack_seen <= 1'b1;
    // rx clock is held low, so any sample pulse is spurious
    if (!sys_rst_in && stat[0].rx_sample) rx_seen <= 1'b1;
    if (stat[0].cts_edge) edge_seen <= 1'b1;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task wait_n(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cfg_in[0].auto_en = 1'b1;
    cfg_in[1].sync_mode = 1'b1;
    wait_n(5);
    chk({4'h0, data_oe_out, chain_out, wreq_is_dma_out}, 8'h00);
    chk({4'h0, rts_n_out, tr_n_out}, 8'h0f);
    sys_rst_in = 1'b0;
    wait_n(4);
    $display("test reset done");
    u_host.plain(1'b0, 1'b1, 1'b1, 8'ha5);
    chk(last_acc.wdata, 8'ha5);
    chk({last_acc.is_data, last_acc.chan_b}, 8'h02);
    u_host.plain(1'b0, 1'b0, 1'b0, 8'h3c);
    chk({last_acc.is_data, last_acc.chan_b}, 8'h01);
    u_host.plain(1'b1, 1'b0, 1'b1, 8'h00);
    chk(read_byte, rdata_in);
    chk({7'h0, data_oe_out}, 8'h00);
    $display("test plain bus done");
    muxed_mode_in = 1'b1;
    u_host.muxed(1'b0, 8'h0b, 8'h96);
    chk(last_acc.addr, 8'h0b);
    chk({last_acc.wdata[0], last_acc.chan_b}, 8'h01);
    muxed_mode_in = 1'b0;
    $display("test muxed bus done");
    u_host.strobes(1'b0, 1'b0);
    wait_n(6);
    chk({7'h0, hw_reset_out}, 8'h01);
    u_host.strobes(1'b1, 1'b1);
    wait_n(6);
    $display("test coincidence done");
    chain_in = 1'b0;
    wait_n(8);
    chk({7'h0, chain_out}, 8'h00);
    chain_in = 1'b1;
    wait_n(8);
    chk({7'h0, chain_out}, 8'h01);
    irq_under_service_in = 1'b1;
    wait_n(8);
    chk({7'h0, chain_out}, 8'h00);
    irq_under_service_in = 1'b0;
    irq_pending_in = 1'b1;
    wait_n(8);
    chk({7'h0, irq_n_oe_out}, 8'h01);
    irq_ack_n_in = 1'b0;
    u_host.plain(1'b1, 1'b1, 1'b0, 8'h00);
    chk(read_byte, vector_in);
    chk({7'h0, ack_seen}, 8'h01);
    irq_ack_n_in = 1'b1;
    irq_pending_in = 1'b0;
    $display("test interrupt chain done");
    cfg_in[0].rts_bit = 1'b1;
    cfg_in[1].rts_bit = 1'b1;
    wait_n(4);
    chk({6'h0, rts_n_out}, 8'h00);
    cfg_in[0].rts_bit = 1'b0;
    cfg_in[1].rts_bit = 1'b0;
    wait_n(6);
    // channel 0 waits for an empty transmitter, channel 1 follows at once
    chk({6'h0, rts_n_out}, 8'h02);
    tx_empty_in = 2'h3;
    wait_n(6);
    chk({6'h0, rts_n_out}, 8'h03);
    cfg_in[0].tr_bit = 1'b1;
    wreq_is_dma_in = 2'h1;
    wreq_level_in = 2'h1;
    wait_n(6);
    chk({6'h0, tr_n_out}, 8'h02);
    chk({4'h0, wreq_is_dma_out, wreq_oe_out}, 8'h05);
    chk({7'h0, stat[0].tx_enable}, 8'h00);
    chk({7'h0, stat[0].rx_enable}, 8'h00);
    modem_in[0].cts_n = 1'b0;
    modem_in[0].dcd_n = 1'b0;
    cfg_in[1].rx_mode = 2'h2;
    sync_hit_in = 2'h2;
    wait_n(4);
    chk({6'h0, stat[0].tx_enable, stat[0].rx_enable}, 8'h03);
    chk({7'h0, edge_seen}, 8'h01);
    chk({4'h0, sync_oe_out, sync_out}, 8'h09);
    chk({7'h0, rx_seen}, 8'h00);
    $display("test modem done");
    stop_test();
  end
  initial begin
    wait_n(3000);
    errors++;
    stop_test();
  end
endmodule
